// >>> design/csr_regs.vh
/*
  register offsets, field positions, reset values and decode constants
  of the charge setting register group. assumes an 8-bit register port
  fed by the serial control bus front end of the chip.
*/
// Contract
// - range bit 0 picks 5-35 mA at 1 mA; 1 picks 40-300 mA at 10 mA
// - charge target from five-bit code bits 6..2 and base per range
// - over 35 mA clamps to 35 in low range; over 300 to 200 high
// - all-ones charge code selects external resistor; the clamp still applies
// - disable bit 1 of charge register stops charging; resets 0
// - bit 0 of charge register selects high impedance; resets 0
// - termination: 500 uA plus code*500 uA, or 6 mA plus code*1 mA
// - termination above 5 mA in range 0 clamps to 5 mA
// - termination enable bit 1 enables termination; resets to 1
// - termination suppressed while any other control loop is active
// - regulation code bits 7..1 weigh 640 mV down to 10 mV
// - regulation target 3.6 V plus code*10 mV, clamped at 4.65 V
// - reset loads termination 1001 0010 and regulation 1001 0110
`ifndef CSR_REGS_VH
`define CSR_REGS_VH
`define CSR_ADDR_CHARGE 8'h03
`define CSR_ADDR_TERM 8'h04
`define CSR_ADDR_VREG 8'h05
`define CSR_RST_CHARGE 8'h80
`define CSR_RST_TERM 8'h92
`define CSR_RST_VREG 8'h96
`define CSR_BIT_RANGE 7
`define CSR_CODE_MSB 6
`define CSR_CODE_LSB 2
`define CSR_BIT_DISABLE 1
`define CSR_BIT_HIZ 0
`define CSR_BIT_TE 1
`define CSR_VREG_MSB 7
`define CSR_VREG_LSB 1
`define CSR_CODE_ONES 5'h1F
// charge currents in mA
`define CSR_ICHG_LO_BASE 10'h005
`define CSR_ICHG_LO_MAX 10'h023
`define CSR_ICHG_HI_BASE 10'h028
`define CSR_ICHG_HI_STEP 10'h00A
`define CSR_ICHG_HI_MAX 10'h12C
`define CSR_ICHG_HI_CLAMP 10'h0C8
// termination currents in units of 500 uA
`define CSR_ITERM_LO_BASE 7'h01
`define CSR_ITERM_LO_MAX 7'h0A
`define CSR_ITERM_HI_BASE 7'h0C
// regulation voltage in mV
`define CSR_VREG_BASE 13'h0E10
`define CSR_VREG_STEP 13'h000A
`define CSR_VREG_MAX 13'h122A
`endif

// >>> design/csr_charge_settings.v
/*
  charge setting register group: charge current, termination and
  battery regulation registers with decoded targets, clamped except termination in range 1.
  assumes a synchronous single-cycle register port from the serial bus.
*/
`timescale 1ns/1ps
`include "csr_regs.vh"

module csr_charge_settings (
  // clock and reset
  input wire clk_i,
  input wire reset_i,
  // register port
  input wire wr_en_i,
  input wire rd_en_i,
  input wire [7:0] addr_i,
  input wire [7:0] wr_data_i,
  output reg [7:0] rd_data_o,
  // analog loop status
  input wire other_loop_active_i,
  // decoded controls
  output reg [9:0] charge_current_ma_o,
  output reg use_charge_set_resistor_o,
  output reg charge_disable_o,
  output reg high_impedance_select_o,
  output reg [6:0] term_current_half_ma_o,
  output reg termination_active_o,
  output reg [12:0] battery_regulation_mv_o
);

  reg [7:0] charge_current_control;
  reg [7:0] termination_precharge_control;
  reg [7:0] battery_voltage_control;
  reg [7:0] next_rd_data;
  reg [9:0] next_ichg;
  reg [9:0] ichg_raw;
  reg [6:0] next_iterm;
  reg [6:0] iterm_raw;
  reg [12:0] next_vreg;
  reg [12:0] vreg_raw;
  wire [4:0] charge_current_code;
  wire [4:0] term_current_code;
  wire [6:0] battery_regulation_code;

  assign charge_current_code =
    charge_current_control[`CSR_CODE_MSB:`CSR_CODE_LSB];
  assign term_current_code =
    termination_precharge_control[`CSR_CODE_MSB:`CSR_CODE_LSB];
  assign battery_regulation_code =
    battery_voltage_control[`CSR_VREG_MSB:`CSR_VREG_LSB];

  // register writes; all bits stored as written, clamping is on decode
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      charge_current_control <= `CSR_RST_CHARGE;
      termination_precharge_control <= `CSR_RST_TERM;
      battery_voltage_control <= `CSR_RST_VREG;
    end
    else if (wr_en_i)
    begin
      if (addr_i == `CSR_ADDR_CHARGE)
        charge_current_control <= wr_data_i;
      // bit 0 kept as plain storage
      else if (addr_i == `CSR_ADDR_TERM)
        termination_precharge_control <= wr_data_i;
      else if (addr_i == `CSR_ADDR_VREG)
        battery_voltage_control <= wr_data_i;
    end
  end

  // readback; unmapped offsets read zero
  always @*
  begin
    if (addr_i == `CSR_ADDR_CHARGE)
      next_rd_data = charge_current_control;
    else if (addr_i == `CSR_ADDR_TERM)
      next_rd_data = termination_precharge_control;
    else if (addr_i == `CSR_ADDR_VREG)
      next_rd_data = battery_voltage_control;
    else
      next_rd_data = 8'h00;
  end

  // charge current decode
  always @*
  begin
    // range select picks base and step
    if (!charge_current_control[`CSR_BIT_RANGE])
    begin
      ichg_raw = `CSR_ICHG_LO_BASE + {5'h00, charge_current_code};
      if (ichg_raw > `CSR_ICHG_LO_MAX)
        next_ichg = `CSR_ICHG_LO_MAX;
      else
        next_ichg = ichg_raw;
    end
    else
    begin
      // high range 10 mA steps
      // largest code gives 350 mA, so 10 bits never overflow
      ichg_raw = `CSR_ICHG_HI_BASE +
        charge_current_code * `CSR_ICHG_HI_STEP;
      // high range clamp; codes 27 to 31 exceed it and load 200 mA
      if (ichg_raw > `CSR_ICHG_HI_MAX)
        next_ichg = `CSR_ICHG_HI_CLAMP;
      else
        next_ichg = ichg_raw;
    end
  end

  // termination current decode, units of 500 uA
  always @*
  begin
    // range 0 half-mA steps, range 1 one-mA steps
    if (!termination_precharge_control[`CSR_BIT_RANGE])
    begin
      iterm_raw = `CSR_ITERM_LO_BASE + {2'b00, term_current_code};
      if (iterm_raw > `CSR_ITERM_LO_MAX)
        next_iterm = `CSR_ITERM_LO_MAX;
      else
        next_iterm = iterm_raw;
    end
    else
    begin
      iterm_raw = `CSR_ITERM_HI_BASE + {1'b0, term_current_code, 1'b0};
      next_iterm = iterm_raw;
    end
  end

  // regulation voltage decode
  always @*
  begin
    // base plus 10 mV steps, clamped
    vreg_raw = `CSR_VREG_BASE +
      battery_regulation_code * `CSR_VREG_STEP;
    if (vreg_raw > `CSR_VREG_MAX)
      next_vreg = `CSR_VREG_MAX;
    else
      next_vreg = vreg_raw;
  end

  // registered outputs so the analog side sees no decode glitches
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rd_data_o <= 8'h00;
      charge_current_ma_o <= 10'h000;
      use_charge_set_resistor_o <= 1'b0;
      charge_disable_o <= 1'b0;
      high_impedance_select_o <= 1'b0;
      term_current_half_ma_o <= 7'h00;
      termination_active_o <= 1'b0;
      battery_regulation_mv_o <= 13'h0000;
    end
    else
    begin
      if (rd_en_i)
        rd_data_o <= next_rd_data;
      charge_current_ma_o <= next_ichg;
      use_charge_set_resistor_o <=
        (charge_current_code == `CSR_CODE_ONES);
      charge_disable_o <= charge_current_control[`CSR_BIT_DISABLE];
      high_impedance_select_o <= charge_current_control[`CSR_BIT_HIZ];
      term_current_half_ma_o <= next_iterm;
      termination_active_o <=
        termination_precharge_control[`CSR_BIT_TE] & ~other_loop_active_i;
      battery_regulation_mv_o <= next_vreg;
    end
  end

endmodule

// >>> dv/csr_chk.sv
/* assertions for csr_charge_settings
   sees only the top ports; bound at the foot */
`timescale 1ns/1ps
module csr_chk (
  // clock, reset, register port
  input wire clk_i, reset_i, wr_en_i, rd_en_i,
  input wire [7:0] addr_i, wr_data_i, rd_data_o,
  // loop status and decoded targets
  input wire other_loop_active_i, use_charge_set_resistor_o,
  input wire charge_disable_o, high_impedance_select_o,
  input wire termination_active_o,
  input wire [9:0] charge_current_ma_o,
  input wire [6:0] term_current_half_ma_o,
  input wire [12:0] battery_regulation_mv_o
);
  wire wc = wr_en_i && addr_i == 8'h03;
  wire wt = wr_en_i && addr_i == 8'h04;
  wire wv = wr_en_i && addr_i == 8'h05;
  function automatic [12:0] ma(input [7:0] d);
    ma = d[7] ? 13'h028 + 13'h00A * d[6:2] : 13'h005 + d[6:2];
    if (ma > (d[7] ? 13'h12C : 13'h023))
      ma = d[7] ? 13'h0C8 : 13'h023;
  endfunction
  function automatic [12:0] mv(input [7:0] d);
    mv = 13'h0E10 + 13'h000A * d[7:1];
    if (mv > 13'h122A)
      mv = 13'h122A;
  endfunction
  function automatic [6:0] th(input [7:0] d);
    th = d[7] ? 7'h0C + 7'h02 * d[6:2] : 7'h01 + d[6:2];
    // low range saturates, high range never exceeds 37 mA
    if (!d[7] && th > 7'h0A)
      th = 7'h0A;
  endfunction
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  chk_charge_calc: assert property (
    wc |-> ##2 charge_current_ma_o == ma($past(wr_data_i, 2)))
    else $error("charge target wrong");
  chk_resistor_flag: assert property (
    wc |-> ##2 use_charge_set_resistor_o
      == ($past(wr_data_i, 2) >> 2 == 8'h1F || $past(wr_data_i, 2) >> 2 == 8'h3F))
    else $error("resistor flag wrong");
  chk_disable_bit: assert property (
    wc |-> ##2 charge_disable_o == $past(wr_data_i[1], 2))
    else $error("disable bit wrong");
  chk_hiz_bit: assert property (
    wc |-> ##2 high_impedance_select_o == $past(wr_data_i[0], 2))
    else $error("hiz bit wrong");
  chk_term_calc: assert property (
    wt |-> ##2 term_current_half_ma_o == th($past(wr_data_i, 2)))
    else $error("termination target wrong");
  chk_term_gate: assert property (
    other_loop_active_i |=> !termination_active_o)
    else $error("termination not suppressed");
  chk_vreg_calc: assert property (
    wv |-> ##2 battery_regulation_mv_o == mv($past(wr_data_i, 2)))
    else $error("regulation target wrong");
  chk_vreg_limit: assert property (
    battery_regulation_mv_o <= 13'h122A)
    else $error("regulation above limit");
  cover property (wc && wr_data_i[6:2] == 5'h1F);
  cover property (other_loop_active_i ##1 !other_loop_active_i);
  cover property (wv && wr_data_i[7:1] > 7'h69);
endmodule
bind csr_charge_settings csr_chk chk (.*);

// >>> dv/csr_charge_settings_tb.sv
/* self-checking bench for csr_charge_settings
   drives the register port at the falling edge */
`timescale 1ns/1ps
module csr_charge_settings_tb;
  logic clk_i = 0, reset_i = 1, wr_en_i = 0, rd_en_i = 0;
  logic other_loop_active_i = 0;
  logic [7:0] addr_i = 8'h00, wr_data_i = 8'h00, rd_data_o;
  logic [9:0] charge_current_ma_o;
  logic use_charge_set_resistor_o, charge_disable_o;
  logic high_impedance_select_o, termination_active_o;
  logic [6:0] term_current_half_ma_o;
  logic [12:0] battery_regulation_mv_o;
  int n_errors = 0, compares = 0;
  logic [7:0] rv [4] = '{8'h80, 8'h92, 8'h96, 8'h00};
  logic [7:0] cd [7] = '{8'h00, 8'h78, 8'h7C, 8'h80, 8'hE8, 8'hEC, 8'h03};
  logic [12:0] cm [7] = '{13'h005, 13'h023, 13'h023, 13'h028, 13'h12C,
    13'h0C8, 13'h005};
  logic [7:0] vd [4] = '{8'hFE, 8'h00, 8'hD3, 8'h2D};
  logic [12:0] vm [4] = '{13'h122A, 13'h0E10, 13'h122A, 13'h0EEC};
  csr_charge_settings dut (.*);
  always #4 clk_i = ~clk_i;
  task cmp(input logic [12:0] got, input logic [12:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // outputs settle one rising edge after the write edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_en_i = 1;
    addr_i = a;
    wr_data_i = d;
    @(negedge clk_i);
    wr_en_i = 0;
    @(negedge clk_i);
  endtask
  task rd(input logic [7:0] a);
    @(negedge clk_i);
    rd_en_i = 1;
    addr_i = a;
    @(negedge clk_i);
    rd_en_i = 0;
  endtask
  task print_verdict;
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #20000;
    n_errors++;
    print_verdict;
  end
  initial
  begin
    repeat (16) @(negedge clk_i);
    reset_i = 0;
    @(negedge clk_i);
    for (int i = 0; i < 4; i++)
    begin
      rd(8'h03 + i[7:0]);
      cmp(rd_data_o, rv[i]);
    end
    cmp(charge_current_ma_o, 13'h028);
    cmp(term_current_half_ma_o, 13'h014);
    cmp(termination_active_o, 13'h001);
    cmp(battery_regulation_mv_o, 13'h10FE);
    for (int i = 0; i < 7; i++)
    begin
      wr(8'h03, cd[i]);
      cmp(charge_current_ma_o, cm[i]);
    end
    cmp(charge_disable_o, 13'h001);
    cmp(high_impedance_select_o, 13'h001);
    // termination code first, then the all-ones charge code
    wr(8'h04, 8'h06);
    wr(8'h03, 8'hFC);
    cmp(use_charge_set_resistor_o, 13'h001);
    cmp(charge_current_ma_o, 13'h0C8);
    wr(8'h04, 8'h7E);
    cmp(term_current_half_ma_o, 13'h00A);
    other_loop_active_i = 1;
    @(negedge clk_i);
    cmp(termination_active_o, 13'h000);
    other_loop_active_i = 0;
    wr(8'h04, 8'hFC);
    cmp(term_current_half_ma_o, 13'h04A);
    cmp(termination_active_o, 13'h000);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h05, vd[i]);
      cmp(battery_regulation_mv_o, vm[i]);
      rd(8'h05);
      cmp(rd_data_o, vd[i]);
    end
    print_verdict;
  end
endmodule
